//--- rtl/rxs_status_bank.sv
// receive error, wake-up event, queue status and collision position registers
//
// Behaviour
// RULE_01: soft framing error sets event bit 5.
// RULE_02: hard framing error sets event bit 4.
// RULE_03: wake timer expiry sets bit 3 only when every-timeout option selected.
// RULE_04: amplitude beyond reference plus delta sets event bit 2.
// RULE_05: phase beyond reference plus delta sets event bit 1.
// RULE_06: capacitance beyond reference plus delta sets event bit 0.
// RULE_07: reading the event register clears it entirely.
// RULE_08: event register clears at power-up and on set-default.
// RULE_09: seven-bit count of unread queue bytes, range zero to ninety-six.
// RULE_10: status-2 bit 6 on underflow, bit 5 on overflow.
// RULE_11: bit 4 flags incomplete last byte, bits 3..1 give valid bits.
// RULE_12: bit 0 flags missing last parity, also counted as framing error.
// RULE_13: empty queue reads count zero, clears incomplete flag and low two bits.
// RULE_14: host reads both queue status registers before queue data.
// RULE_15: both queue status and collision registers clear on reset, default, clear.
// RULE_16: collision bits 7..4 hold full bytes before first collision.
// RULE_17: collision bits 3..1 hold bits before collision in that byte.
// RULE_18: collision position updates only inside the anticollision window.
// RULE_19: collision bit 0 marks first collision in a parity bit, an error.
// RULE_20: main event bit 0 shows any pending event until event register read.
// RULE_21: event flags stay set until read or default or clear command; cmd_clear leaves them set here.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rxs_regs.svh"
module rxs_status_bank
  import rxs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // direct commands
  input wire logic cmd_set_default,
  input wire logic cmd_clear,
  // receive side events
  input wire rxs_rx_err_t rx_err,
  input wire rxs_last_t rx_last,
  input wire rxs_coll_t coll,
  input wire logic wake_timer_expired,
  input wire rxs_meas_t meas,
  // queue traffic
  input wire logic queue_push,
  input wire logic queue_pop,
  // summary bit toward the main event register
  output logic main_err_pending
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // true when a measurement lies further than delta from its reference
  function automatic logic beyond_delta(input logic [7:0] value, input logic [7:0] ref_v,
                                        input logic [7:0] delta);
    logic [7:0] diff;
    diff = (value >= ref_v) ? (value - ref_v) : (ref_v - value);
    beyond_delta = diff > delta;
  endfunction : beyond_delta

  // register index from a byte address; low two bits ignored
  function automatic logic [7:0] word_index(input logic [31:0] adr);
    word_index = adr[9:2];
  endfunction : word_index

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] err_q, err_d;
  logic [6:0] fill_q, fill_d;
  logic unf_q, unf_d;
  logic ovr_q, ovr_d;
  logic ncp_q, ncp_d;
  logic [2:0] lb_q, lb_d;
  logic np_q, np_d;
  logic [7:0] coll_q, coll_d;
  logic coll_seen_q, coll_seen_d;
  logic every_timeout_q;
  logic [7:0] amp_ref_q, pha_ref_q, cap_ref_q;
  logic [7:0] amp_delta_q, pha_delta_q, cap_delta_q;
  logic ack_q;
  logic [31:0] dat_q, dat_d;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic [7:0] idx = word_index(wb_adr_i);
  // a request is served once; the ack cycle itself is not a new request
  wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic rd_req = req & ~wb_we_i;
  wire logic wr_req = req & wb_we_i & wb_sel_i[0];
  wire logic hit_err = (idx == `RXS_IDX_ERR_WAKE);
  wire logic rd_clear_err = rd_req & hit_err;
  wire logic wr_ctrl = wr_req & (idx == `RXS_IDX_WAKE_CTRL);
  wire logic wr_amp_ref = wr_req & (idx == `RXS_IDX_AMP_REF);
  wire logic wr_pha_ref = wr_req & (idx == `RXS_IDX_PHA_REF);
  wire logic wr_cap_ref = wr_req & (idx == `RXS_IDX_CAP_REF);
  wire logic wr_amp_delta = wr_req & (idx == `RXS_IDX_AMP_DELTA);
  wire logic wr_pha_delta = wr_req & (idx == `RXS_IDX_PHA_DELTA);
  wire logic wr_cap_delta = wr_req & (idx == `RXS_IDX_CAP_DELTA);

  // both commands wipe the queue and collision state, only default wipes events
  wire logic queue_wipe = cmd_set_default | cmd_clear;
  wire logic queue_empty = (fill_q == 7'h00);
  // queue abuse in this cycle, kept even when a wipe lands with it
  wire logic ovr_hit = queue_push & ~queue_pop & (fill_q == `RXS_FILL_MAX);
  wire logic unf_hit = queue_pop & ~queue_push & queue_empty;

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  // wake-up comparisons, one per measurement kind
  wire logic wam_hit = meas.valid & (meas.kind == RXS_MEAS_AMP) &
                       beyond_delta(meas.value, amp_ref_q, amp_delta_q); // RULE_04
  wire logic wph_hit = meas.valid & (meas.kind == RXS_MEAS_PHASE) &
                       beyond_delta(meas.value, pha_ref_q, pha_delta_q); // RULE_05
  wire logic wcap_hit = meas.valid & (meas.kind == RXS_MEAS_CAP) &
                        beyond_delta(meas.value, cap_ref_q, cap_delta_q); // RULE_06
  wire logic wt_hit = wake_timer_expired & every_timeout_q; // RULE_03
  // missing parity on the last byte is a framing error that corrupts data
  wire logic np_hit = rx_last.frame_end & rx_last.missing_parity; // RULE_12
  // a first collision in the anticollision window that falls on a parity bit
  wire logic coll_take = coll.detect & coll.anticoll_window & ~coll_seen_q; // RULE_18
  wire logic coll_par_hit = coll_take & coll.in_parity; // RULE_19

  wire logic [7:0] err_set = {
    rx_err.crc_err,
    rx_err.par_err | coll_par_hit,
    rx_err.soft_framing, // RULE_01
    rx_err.hard_framing | np_hit, // RULE_02
    wt_hit,
    wam_hit,
    wph_hit,
    wcap_hit
  };

  // ----------------------------------------------------------------
  // event register next value
  // ----------------------------------------------------------------
  // a new event in the clearing cycle survives: set wins over clear
  always_comb begin
    err_d = err_q;
    if (rd_clear_err | cmd_set_default) begin
      err_d = `RXS_RST_BYTE; // RULE_07 RULE_08
    end
    err_d = err_d | err_set; // RULE_21
  end

  // ----------------------------------------------------------------
  // queue fill count and flags
  // ----------------------------------------------------------------
  // count saturates at both ends so the flags record the abuse instead
  always_comb begin
    fill_d = fill_q;
    unf_d = unf_q;
    ovr_d = ovr_q;
    if (queue_push & ~queue_pop) begin
      if (fill_q == `RXS_FILL_MAX) begin
        ovr_d = 1'b1; // RULE_10
      end else begin
        fill_d = fill_q + 7'h01; // RULE_09
      end
    end else if (queue_pop & ~queue_push) begin
      if (queue_empty) begin
        unf_d = 1'b1; // RULE_10
      end else begin
        fill_d = fill_q - 7'h01; // RULE_09
      end
    end
    if (queue_wipe) begin
      // set wins over clear, so an abuse in the wiping cycle still shows
      fill_d = 7'h00; // RULE_15
      unf_d = unf_hit; // RULE_10
      ovr_d = ovr_hit; // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // last byte description
  // ----------------------------------------------------------------
  // once the queue drains the incomplete flag and the low two valid-bit bits are cleared
  always_comb begin
    ncp_d = ncp_q;
    lb_d = lb_q;
    np_d = np_q;
    if (rx_last.frame_end) begin
      ncp_d = rx_last.last_incomplete; // RULE_11
      lb_d = rx_last.last_incomplete ? rx_last.last_bits : 3'h0; // RULE_11
      np_d = rx_last.missing_parity; // RULE_12
    end else if (queue_empty) begin
      ncp_d = 1'b0; // RULE_13
      lb_d[1:0] = 2'h0; // RULE_13
    end
    if (queue_wipe) begin
      ncp_d = 1'b0; // RULE_15
      lb_d = 3'h0;
      np_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // collision position
  // ----------------------------------------------------------------
  // only the first collision of a frame counts; a new frame re-arms
  always_comb begin
    coll_d = coll_q;
    coll_seen_d = coll_seen_q;
    if (coll.frame_start) begin
      coll_seen_d = 1'b0;
    end
    if (coll_take) begin
      coll_d = {coll.full_bytes, coll.bits, coll.in_parity}; // RULE_16 RULE_17 RULE_19
      coll_seen_d = 1'b1;
    end
    if (queue_wipe) begin
      coll_d = `RXS_RST_BYTE; // RULE_15
      coll_seen_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  // with an empty queue the count field reads zero regardless of lag
  wire logic [7:0] fill_rd = queue_empty ? `RXS_RST_BYTE : {1'b0, fill_q}; // RULE_13
  wire logic [7:0] flags_rd = {1'b0, unf_q, ovr_q, ncp_q, lb_q, np_q};
  wire logic [7:0] ctrl_rd = {7'h00, every_timeout_q};
  wire logic [7:0] rd_byte =
    (idx == `RXS_IDX_ERR_WAKE) ? err_q :
    (idx == `RXS_IDX_FILL) ? fill_rd :
    (idx == `RXS_IDX_FLAGS_LB) ? flags_rd :
    (idx == `RXS_IDX_COLL) ? coll_q :
    (idx == `RXS_IDX_WAKE_CTRL) ? ctrl_rd :
    (idx == `RXS_IDX_AMP_REF) ? amp_ref_q :
    (idx == `RXS_IDX_PHA_REF) ? pha_ref_q :
    (idx == `RXS_IDX_CAP_REF) ? cap_ref_q :
    (idx == `RXS_IDX_AMP_DELTA) ? amp_delta_q :
    (idx == `RXS_IDX_PHA_DELTA) ? pha_delta_q :
    (idx == `RXS_IDX_CAP_DELTA) ? cap_delta_q :
    `RXS_RST_BYTE;

  // data held stable for the ack cycle, zero otherwise
  always_comb begin
    dat_d = 32'h0000_0000;
    if (rd_req) begin
      dat_d = {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // status flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_q <= `RXS_RST_BYTE; // RULE_08
      fill_q <= 7'h00;
      unf_q <= 1'b0;
      ovr_q <= 1'b0;
      ncp_q <= 1'b0;
      lb_q <= 3'h0;
      np_q <= 1'b0;
      coll_q <= `RXS_RST_BYTE; // RULE_15
      coll_seen_q <= 1'b0;
    end else begin
      err_q <= err_d;
      fill_q <= fill_d;
      unf_q <= unf_d;
      ovr_q <= ovr_d;
      ncp_q <= ncp_d;
      lb_q <= lb_d;
      np_q <= np_d;
      coll_q <= coll_d;
      coll_seen_q <= coll_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // wake-up configuration flops
  // ----------------------------------------------------------------
  // set-default returns the detector to its reset, option-off state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      every_timeout_q <= 1'b0;
      amp_ref_q <= `RXS_RST_BYTE;
      pha_ref_q <= `RXS_RST_BYTE;
      cap_ref_q <= `RXS_RST_BYTE;
      amp_delta_q <= `RXS_RST_BYTE;
      pha_delta_q <= `RXS_RST_BYTE;
      cap_delta_q <= `RXS_RST_BYTE;
    end else if (cmd_set_default) begin
      every_timeout_q <= 1'b0;
      amp_ref_q <= `RXS_RST_BYTE;
      pha_ref_q <= `RXS_RST_BYTE;
      cap_ref_q <= `RXS_RST_BYTE;
      amp_delta_q <= `RXS_RST_BYTE;
      pha_delta_q <= `RXS_RST_BYTE;
      cap_delta_q <= `RXS_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        every_timeout_q <= wb_dat_i[`RXS_WC_EVERY];
      end
      if (wr_amp_ref) begin
        amp_ref_q <= wb_dat_i[7:0];
      end
      if (wr_pha_ref) begin
        pha_ref_q <= wb_dat_i[7:0];
      end
      if (wr_cap_ref) begin
        cap_ref_q <= wb_dat_i[7:0];
      end
      if (wr_amp_delta) begin
        amp_delta_q <= wb_dat_i[7:0];
      end
      if (wr_pha_delta) begin
        pha_delta_q <= wb_dat_i[7:0];
      end
      if (wr_cap_delta) begin
        cap_delta_q <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // one wait state: ack a cycle after the request, dropped right after
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  // summary stays up until the event register itself is read or set-default clears it
  assign main_err_pending = |err_q; // RULE_20

endmodule : rxs_status_bank
`default_nettype wire

//--- include/rxs_regs.svh
// register offsets, field positions and reset values of the receive status bank
`ifndef RXS_REGS_SVH
`define RXS_REGS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RXS_IDX_ERR_WAKE 8'h19
`define RXS_IDX_FILL 8'h1A
`define RXS_IDX_FLAGS_LB 8'h1B
`define RXS_IDX_COLL 8'h1C
`define RXS_IDX_WAKE_CTRL 8'h30
`define RXS_IDX_AMP_REF 8'h31
`define RXS_IDX_PHA_REF 8'h32
`define RXS_IDX_CAP_REF 8'h33
`define RXS_IDX_AMP_DELTA 8'h34
`define RXS_IDX_PHA_DELTA 8'h35
`define RXS_IDX_CAP_DELTA 8'h36
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RXS_EW_CRC 7
`define RXS_EW_PAR 6
`define RXS_EW_SOFT 5
`define RXS_EW_HARD 4
`define RXS_EW_WT 3
`define RXS_EW_WAM 2
`define RXS_EW_WPH 1
`define RXS_EW_WCAP 0
`define RXS_F2_UNF 6
`define RXS_F2_OVR 5
`define RXS_F2_NCP 4
`define RXS_F2_NP 0
`define RXS_WC_EVERY 0
// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define RXS_RST_BYTE 8'h00
`define RXS_FILL_MAX 7'h60
`endif

//--- include/rxs_pkg.sv
// types shared by the receive status bank
package rxs_pkg;
  // receive error pulses from the framing logic
  typedef struct packed {
    logic crc_err;
    logic par_err;
    logic soft_framing;
    logic hard_framing;
  } rxs_rx_err_t;
  // end-of-frame description of the last received byte
  typedef struct packed {
    logic frame_end;
    logic last_incomplete;
    logic [2:0] last_bits;
    logic missing_parity;
  } rxs_last_t;
  // collision report from the bit decoder
  typedef struct packed {
    logic frame_start;
    logic anticoll_window;
    logic detect;
    logic [3:0] full_bytes;
    logic [2:0] bits;
    logic in_parity;
  } rxs_coll_t;
  // one measurement result for the wake-up detector
  typedef enum logic [1:0] {
    RXS_MEAS_AMP,
    RXS_MEAS_PHASE,
    RXS_MEAS_CAP
  } rxs_meas_kind_t;
  typedef struct packed {
    logic valid;
    rxs_meas_kind_t kind;
    logic [7:0] value;
  } rxs_meas_t;
endpackage : rxs_pkg

//--- dv/rxs_host_mdl.sv
// host model issuing classic wishbone single cycles
`timescale 1ns/10ps
`default_nettype none
module rxs_host_mdl (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [31:0] adr,
  output logic [31:0] dat,
  output logic [3:0] sel,
  input wire logic [31:0] dat_i,
  input wire logic ack
);
  int timeouts = 0;
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // quiet bus from time zero
  initial begin
    {cyc, stb, we, adr, dat, sel} = '0;
  end
  // request held until ack is sampled; released lines carry junk
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h000000, idx, 2'b00};
    dat <= {24'h000000, wd};
    sel <= 4'h1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    timeouts += (ack !== 1'b1);
    rd = dat_i[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~adr;
    dat <= ~dat;
  endtask : xfer
  // both queue status bytes, fetched before any queue data
  task automatic queue_status(output logic [7:0] cnt, output logic [7:0] flg);
    xfer(1'b0, 8'h1A, 8'h00, cnt);
    xfer(1'b0, 8'h1B, 8'h00, flg);
  endtask : queue_status
endmodule : rxs_host_mdl
`default_nettype wire

//--- dv/rxs_status_bank_props.sv
// assertions on the ports of the receive status bank
`timescale 1ns/10ps
`default_nettype none
module rxs_status_bank_props
  import rxs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmd_set_default,
  input wire logic cmd_clear,
  input wire rxs_rx_err_t rx_err,
  input wire rxs_last_t rx_last,
  input wire rxs_coll_t coll,
  input wire logic wake_timer_expired,
  input wire rxs_meas_t meas,
  input wire logic queue_push,
  input wire logic queue_pop,
  input wire logic main_err_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // any_ev is broad on purpose: may set a flag, so clear checks skip it
  wire logic take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic rd_ev = take & ~wb_we_i & (wb_adr_i[9:2] == 8'h19);
  wire logic any_ev = (|rx_err) | (rx_last.frame_end & rx_last.missing_parity)
    | coll.detect | wake_timer_expired | meas.valid;
  property p_ack_take; take |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle; !wb_ack_o |-> (wb_dat_o == 32'h00000000); endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_dat_hi; wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000); endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read lanes not zero");
  property p_soft; rx_err.soft_framing |=> main_err_pending; endproperty
  a_soft: assert property (p_soft) else $error("soft flag lost");
  property p_hard; rx_err.hard_framing |=> main_err_pending; endproperty
  a_hard: assert property (p_hard) else $error("hard flag lost");
  property p_mp; rx_last.frame_end && rx_last.missing_parity |=> main_err_pending; endproperty
  a_mp: assert property (p_mp) else $error("parity gap flag lost");
  property p_rdclr; rd_ev && !any_ev |=> !main_err_pending; endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear");
  property p_hold; main_err_pending && !rd_ev && !cmd_set_default |=> main_err_pending;
  endproperty
  a_hold: assert property (p_hold) else $error("event dropped");
  property p_dflt; cmd_set_default && !any_ev |=> !main_err_pending; endproperty
  a_dflt: assert property (p_dflt) else $error("default kept events");
  property p_fill;
    take && !wb_we_i && wb_adr_i[9:2] == 8'h1A |=> (wb_dat_o <= 32'h00000060);
  endproperty
  a_fill: assert property (p_fill) else $error("fill count out of range");
  c_rdclr: cover property (rd_ev && main_err_pending);
  c_dflt: cover property (cmd_set_default && main_err_pending);
  c_clr: cover property (cmd_clear);
endmodule : rxs_status_bank_props
bind rxs_status_bank rxs_status_bank_props u_props (.clk(clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmd_set_default(cmd_set_default), .cmd_clear(cmd_clear), .rx_err(rx_err),
  .rx_last(rx_last), .coll(coll), .wake_timer_expired(wake_timer_expired), .meas(meas),
  .queue_push(queue_push), .queue_pop(queue_pop), .main_err_pending(main_err_pending));
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the receive status register bank
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rxs_pkg::*;
;
  logic clk, reset, cyc, stb, we, ack, cmd_def, cmd_clr, wt, push, pop, pend;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  rxs_rx_err_t rx_err;
  rxs_last_t rx_last;
  rxs_coll_t coll;
  rxs_meas_t meas;
  int fail_count = 0;
  int n_checks = 0;
  rxs_status_bank dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cmd_set_default(cmd_def), .cmd_clear(cmd_clr), .rx_err(rx_err),
    .rx_last(rx_last), .coll(coll), .wake_timer_expired(wt), .meas(meas),
    .queue_push(push), .queue_pop(pop), .main_err_pending(pend));
  rxs_host_mdl host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(wdat),
    .sel(sel), .dat_i(rdat), .ack(ack));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task results;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // a stuck bus ends the run at the next check
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
    if (host.timeouts > 0) begin
      fail_count++;
      results();
    end
  endtask : chk
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.xfer(1'b0, idx, 8'h00, v);
    chk(v, exp);
  endtask : rd
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    host.xfer(1'b1, idx, d, v);
  endtask : wr
  // drop all pulse inputs at the next edge
  task idle;
    @(posedge clk);
    rx_err <= '0;
    rx_last.frame_end <= 1'b0;
    coll.frame_start <= 1'b0;
    coll.detect <= 1'b0;
    {wt, push, pop, cmd_def, cmd_clr, meas.valid} <= '0;
  endtask : idle
  // sampled at the falling edge, well clear of the flop updates
  task pend_is(input logic e);
    @(negedge clk);
    chk({7'h00, pend}, {7'h00, e});
  endtask : pend_is
  task qmove(input int n, input logic out);
    @(posedge clk);
    if (out) pop <= 1'b1;
    else push <= 1'b1;
    repeat (n - 1) @(posedge clk);
    idle();
  endtask : qmove
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(8'h19, 8'h00);
    rd(8'h1A, 8'h00);
    rd(8'h1B, 8'h00);
    rd(8'h1C, 8'h00);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00);
    wr(8'h3F, 8'hA5);
    rd(8'h3F, 8'h00);
    $display("done: reset values");
  endtask : t_reset
  task t_err;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rx_err <= rxs_rx_err_t'(4'h1 << i);
      idle();
      pend_is(1'b1);
      rd(8'h19, 8'h10 << i);
      rd(8'h19, 8'h00);
      pend_is(1'b0);
    end
    @(posedge clk);
    rx_err <= '{1'b0, 1'b0, 1'b1, 1'b0};
    @(posedge clk);
    rx_err <= '{1'b1, 1'b0, 1'b0, 1'b0};
    idle();
    repeat (3) pend_is(1'b1);
    rd(8'h19, 8'hA0);
    $display("done: error flags");
  endtask : t_err
  task t_wake;
    @(posedge clk);
    wt <= 1'b1;
    idle();
    rd(8'h19, 8'h00);
    wr(8'h30, 8'h01);
    @(posedge clk);
    wt <= 1'b1;
    idle();
    rd(8'h19, 8'h08);
    for (int k = 0; k < 3; k++) begin
      wr(8'h31 + 8'(k), 8'h80);
      wr(8'h34 + 8'(k), 8'h10);
      // a distance equal to the delta is not enough
      @(posedge clk);
      meas <= '{1'b1, rxs_meas_kind_t'(k), 8'h90};
      idle();
      rd(8'h19, 8'h00);
      @(posedge clk);
      meas <= '{1'b1, rxs_meas_kind_t'(k), 8'h6F};
      idle();
      rd(8'h19, 8'h04 >> k);
    end
    $display("done: wake events");
  endtask : t_wake
  task t_queue;
    logic [7:0] a, b;
    qmove(96, 1'b0);
    host.queue_status(a, b);
    chk(a, 8'h60);
    chk(b, 8'h00);
    qmove(1, 1'b0);
    rd(8'h1A, 8'h60);
    rd(8'h1B, 8'h20);
    qmove(97, 1'b1);
    rd(8'h1A, 8'h00);
    rd(8'h1B, 8'h60);
    @(posedge clk);
    cmd_clr <= 1'b1;
    idle();
    rd(8'h1B, 8'h00);
    $display("done: queue count");
  endtask : t_queue
  task t_last;
    qmove(1, 1'b0);
    @(posedge clk);
    rx_last <= '{1'b1, 1'b1, 3'h5, 1'b1};
    idle();
    rd(8'h1B, 8'h1B);
    rd(8'h19, 8'h10);
    qmove(1, 1'b1);
    rd(8'h1A, 8'h00);
    rd(8'h1B, 8'h09);
    $display("done: last byte");
  endtask : t_last
  task t_coll;
    @(posedge clk);
    coll <= '{1'b1, 1'b1, 1'b0, 4'h3, 3'h5, 1'b0};
    @(posedge clk);
    coll <= '{1'b0, 1'b1, 1'b1, 4'h3, 3'h5, 1'b0};
    @(posedge clk);
    coll <= '{1'b0, 1'b1, 1'b1, 4'h9, 3'h1, 1'b1};
    idle();
    rd(8'h1C, 8'h3A);
    @(posedge clk);
    cmd_clr <= 1'b1;
    idle();
    rd(8'h1C, 8'h00);
    @(posedge clk);
    coll <= '{1'b1, 1'b0, 1'b0, 4'h2, 3'h7, 1'b1};
    @(posedge clk);
    coll <= '{1'b0, 1'b0, 1'b1, 4'h2, 3'h7, 1'b1};
    idle();
    rd(8'h1C, 8'h00);
    @(posedge clk);
    coll <= '{1'b1, 1'b1, 1'b0, 4'h2, 3'h7, 1'b1};
    @(posedge clk);
    coll <= '{1'b0, 1'b1, 1'b1, 4'h2, 3'h7, 1'b1};
    idle();
    rd(8'h1C, 8'h2F);
    rd(8'h19, 8'h40);
    @(posedge clk);
    rx_err <= '{1'b0, 1'b0, 1'b1, 1'b0};
    @(posedge clk);
    cmd_def <= 1'b1;
    rx_err <= '0;
    idle();
    pend_is(1'b0);
    rd(8'h1C, 8'h00);
    rd(8'h30, 8'h00);
    $display("done: collision");
  endtask : t_coll
  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    reset = 1'b1;
    {cmd_def, cmd_clr, wt, push, pop} = '0;
    rx_err = '0;
    rx_last = '0;
    coll = '0;
    meas = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_err();
    t_wake();
    t_queue();
    t_last();
    t_coll();
    results();
  end
endmodule : testbench
`default_nettype wire
